// >>> verilog/smc_pkg.sv
package smc_pkg;

  // register selects for the plain write port
  typedef enum logic [3:0] {
    SEL_PORT_LOW     = 4'h0,
    SEL_PORT_HIGH    = 4'h1,
    SEL_CLK_RELOAD   = 4'h2,
    SEL_CLK_CONFIG   = 4'h3,
    SEL_AUX          = 4'h4,
    SEL_AUX2         = 4'h5,
    SEL_KB_FLAGS     = 4'h6,
    SEL_TIMER_OUT    = 4'h7,
    SEL_DOUBLE_SPEED = 4'h8
  } smc_reg_sel_t;

  // six-state machine cycle of compatible mode
  typedef enum logic [2:0] {
    MS_S1 = 3'h0,
    MS_S2 = 3'h1,
    MS_S3 = 3'h2,
    MS_S4 = 3'h3,
    MS_S5 = 3'h4,
    MS_S6 = 3'h5
  } smc_mstate_t;

  // field positions
  localparam int TPS_MSB         = 7;
  localparam int TPS_LSB         = 4;
  localparam int AUX_LATCH_BIT   = 0;
  localparam int AUX_XDATA_BIT   = 1;
  localparam int AUX_WS_MSB      = 6;
  localparam int AUX_WS_LSB      = 5;
  localparam int AUX2_STACK_BIT  = 4;
  localparam int AUX2_API_BIT    = 5;
  localparam int TOUT_T0_BIT     = 0;
  localparam int TOUT_T1_BIT     = 1;
  localparam int DSPEED_BIT      = 0;

  // values after reset
  localparam logic [3:0] TPS_RST_COMPAT = 4'h5;
  localparam logic [3:0] TPS_RST_FAST   = 4'h0;
  localparam logic [7:0] CLOCK_RELOAD_DIVIDER_RST       = 8'hFF;
  localparam logic [7:0] CLKCFG_RST     = 8'h00;
  localparam logic [7:0] AUX_RST        = 8'h00;
  localparam logic [7:0] AUX2_RST       = 8'h00;
  localparam logic [7:0] TOUT_RST       = 8'h00;
  localparam logic [7:0] KBF_RST        = 8'h00;
  localparam logic [7:0] PM_ALL_SET     = 8'hFF;
  localparam logic [7:0] PM_ALL_CLR     = 8'h00;

  // counts and limits
  localparam logic [8:0]  DIV_BASE         = 9'h100;
  localparam logic [4:0]  CLOCKS_PER_MCYC  = 5'h06;
  localparam logic [15:0] EXT_EXEC_FLOOR   = 16'h2000;

endpackage : smc_pkg

// >>> verilog/smc_tick_if.sv
`timescale 1ns/1ps
interface smc_tick_if;
  logic       clk_en;
  logic       sys_rst;
  logic       fast_mode;
  logic       t2_unscaled;
  logic [3:0] timer_prescale_select;
  logic       timer_tick;
  logic       t2_tick;
  logic       sample_strobe;

  modport ctrl (
    output clk_en, sys_rst, fast_mode, t2_unscaled, timer_prescale_select,
    input  timer_tick, t2_tick, sample_strobe
  );
  modport presc (
    input  clk_en, sys_rst, fast_mode, t2_unscaled, timer_prescale_select,
    output timer_tick, t2_tick, sample_strobe
  );
endinterface : smc_tick_if

// >>> verilog/smc_prescaler.sv
`timescale 1ns/1ps
module smc_prescaler (
  input  logic    core_clk_in,  // system clock
  smc_tick_if.presc tick_if     // control in, ticks out
);

  logic [3:0] count;
  logic       next_tick;

  // divide ratio is tps+1, so 0 gives full rate and 15 gives 1/16
  assign next_tick = (count >= tick_if.timer_prescale_select);

  // counter uses >= so a smaller tps written mid-count cannot strand it
  always_ff @(posedge core_clk_in) begin
    if (tick_if.sys_rst) begin
      count                 <= 4'h0;
      tick_if.timer_tick    <= 1'b0;
      tick_if.t2_tick       <= 1'b0;
      tick_if.sample_strobe <= 1'b0;
    end else if (tick_if.clk_en) begin
      count                 <= next_tick ? 4'h0 : 4'(count + 4'h1);
      tick_if.timer_tick    <= next_tick;
      tick_if.t2_tick       <= tick_if.t2_unscaled | next_tick;
      tick_if.sample_strobe <= tick_if.fast_mode | next_tick;
    end
  end

endmodule : smc_prescaler

// >>> verilog/smc_system_config.sv
`timescale 1ns/1ps
module smc_system_config #(
  parameter int PORTS = 5,                          // ports 0..PORTS-1, last is fixed quasi
  parameter int PINS  = 8                           // pins per port
) (
  input  logic                      core_clk_in,         // system clock, 25 MHz
  input  logic                      rst_n_in,            // synchronous reset, active low
  input  logic                      clk_en_in,           // freezes all state outside reset when low
  input  logic                      compat_mode_fuse_in, // 1 = compatible, 0 = fast
  input  logic                      tristate_port_fuse_in, // 1 = all but the last port start input-only
  input  logic                      xdata_default_fuse_in, // default of on-chip xdata enable
  input  logic                      reset_pin_in,        // external reset pin level
  input  logic                      reset_polarity_select_in, // polarity pin level
  input  logic                      second_oscillator_source_in, // 1 = oscillator B
  input  logic                      reg_wr_in,           // register write strobe
  input  smc_pkg::smc_reg_sel_t     reg_sel_in,          // register select
  input  logic [2:0]                port_index_in,       // port for mode writes
  input  logic [7:0]                reg_wdata_in,        // write data
  input  logic [2:0]                instr_length_in,     // machine cycles or fast clocks
  input  logic                      timer2_unscaled_mode_in, // timer 2 clock-out or baud
  input  logic                      timer0_overflow_in,  // timer 0 overflow pulse
  input  logic                      timer1_overflow_in,  // timer 1 overflow pulse
  input  logic [7:0]                keyboard_event_in,   // keyboard flag set pulses
  input  logic [15:0]               fetch_addr_in,       // code fetch address
  input  logic                      fetch_external_in,   // address maps to external code
  input  logic                      lock_mode4_in,       // third lock bit active
  output logic                      fast_mode_out,       // captured execution mode
  output logic                      sys_reset_out,       // combined reset, active high
  output logic [PORTS*PINS-1:0]     port_mode_low_bits_out,  // mode bit 0 per pin
  output logic [PORTS*PINS-1:0]     port_mode_high_bits_out, // mode bit 1 per pin
  output logic [7:0]                clock_reload_divider_out, // reload divider register
  output logic [7:0]                clock_config_register_out, // clock config register
  output logic [7:0]                auxiliary_control_register_out, // aux register
  output logic [7:0]                second_auxiliary_control_register_out, // aux2
  output logic [7:0]                keyboard_flag_register_out, // keyboard flags
  output logic [7:0]                timer_output_control_register_out, // toggle enables
  output logic                      double_speed_setting_out, // 1 = no halving
  output logic [3:0]                timer_prescale_select_out, // prescale field
  output logic                      latch_strobe_toggle_enable_out, // strobe may toggle
  output logic                      onchip_xdata_enable_out, // on-chip xdata access
  output logic [1:0]                xdata_wait_states_out, // external data wait states
  output logic                      extended_stack_select_out, // stack in extra RAM
  output logic                      flash_api_enable_out, // flash API access
  output logic [9:0]                sys_clk_divisor_out, // oscillator to system ratio
  output logic                      osc_b_selected_out,  // divisor applies to osc B
  output logic                      fetch_strobe_out,    // one code byte this clock
  output smc_pkg::smc_mstate_t      machine_state_out,   // state within machine cycle
  output logic [4:0]                instr_clocks_out,    // instruction length in clocks
  output logic                      timer_tick_out,      // shared prescaler tick
  output logic                      timer2_tick_out,     // timer 2 time base
  output logic                      pin_sample_out,      // sample timer/interrupt pins
  output logic                      timer0_pin_out,      // timer 0 toggled pin level
  output logic                      timer1_pin_out,      // timer 1 toggled pin level
  output logic                      ext_exec_allow_out   // external fetch permitted
);

  // elaboration-time guards: mode registers are byte wide and port index is three bits
  if (PORTS < 2 || PORTS > 8) $error("PORTS must lie in 2..8");
  if (PINS != 8) $error("PINS must be 8 to match byte-wide mode registers");


  // instruction length: compatible counts machine cycles of six clocks
  function automatic logic [4:0] instr_clocks(input logic fast, input logic [2:0] len);
    logic [4:0] wide;
    wide = {2'b00, len};
    instr_clocks = fast ? wide : 5'(wide * smc_pkg::CLOCKS_PER_MCYC);
  endfunction : instr_clocks

  // advance the six-state cycle
  function automatic smc_pkg::smc_mstate_t next_mstate(input smc_pkg::smc_mstate_t s);
    case (s)
      smc_pkg::MS_S1: next_mstate = smc_pkg::MS_S2;
      smc_pkg::MS_S2: next_mstate = smc_pkg::MS_S3;
      smc_pkg::MS_S3: next_mstate = smc_pkg::MS_S4;
      smc_pkg::MS_S4: next_mstate = smc_pkg::MS_S5;
      smc_pkg::MS_S5: next_mstate = smc_pkg::MS_S6;
      default:        next_mstate = smc_pkg::MS_S1;
    endcase
  endfunction : next_mstate

  // ---- pin synchronisers: three flops, a change counts once stages 2 and 3 agree
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  logic [1:0] pin_level;   // [0] reset pin, [1] polarity pin
  logic       pin_reset_active;
  logic       sys_rst;

  // reset pin idles low with polarity high, an inactive pair, so nothing fires at start-up
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      pin_s1    <= 2'h2;
      pin_s2    <= 2'h2;
      pin_s3    <= 2'h2;
      pin_level <= 2'h2;
    end else if (clk_en_in) begin
      pin_s1 <= {reset_polarity_select_in, reset_pin_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int i = 0; i < 2; i++) begin
        if (pin_s2[i] == pin_s3[i]) pin_level[i] <= pin_s3[i];
      end
    end
  end

  // the three-flop filter drops pulses of one clock; holders meet anyway
  assign pin_reset_active = pin_level[1] ? pin_level[0] : ~pin_level[0];
  assign sys_rst          = ~rst_n_in | pin_reset_active;
  assign sys_reset_out    = sys_rst;

  // ---- mode capture
  logic fast_mode;
  logic reset_fast;

  assign reset_fast = ~compat_mode_fuse_in;

  // fuse is sampled every reset cycle, frozen once reset is released
  always_ff @(posedge core_clk_in) begin
    if (sys_rst) fast_mode <= reset_fast;
  end
  assign fast_mode_out = fast_mode;

  // ---- software configuration registers
  logic [7:0] port_low  [PORTS];
  logic [7:0] port_high [PORTS];
  logic [7:0] clock_reload_divider;
  logic [7:0] clkcfg;
  logic [7:0] aux;
  logic [7:0] aux2;
  logic [7:0] tout;
  logic [7:0] keyboard_flag_register;
  logic       dspeed;

  logic       wr_port_low;
  logic       wr_port_high;
  logic       wr_kbf;
  logic [7:0] kbf_keep_mask;
  logic [7:0] next_kbf;
  logic [7:0] low_reset;
  logic [7:0] high_reset;
  logic [7:0] p0_low_reset;
  logic [7:0] p0_high_reset;

  // decode; the last port is never writable and stays quasi-bidirectional
  assign wr_port_low  = reg_wr_in && reg_sel_in == smc_pkg::SEL_PORT_LOW
                        && 32'(port_index_in) < PORTS - 1;
  assign wr_port_high = reg_wr_in && reg_sel_in == smc_pkg::SEL_PORT_HIGH
                        && 32'(port_index_in) < PORTS - 1;
  assign wr_kbf       = reg_wr_in && reg_sel_in == smc_pkg::SEL_KB_FLAGS;

  // mode encoding {high,low}: 00 quasi, 01 push-pull, 10 input-only, 11 open-drain
  assign low_reset     = smc_pkg::PM_ALL_CLR;
  assign high_reset    = tristate_port_fuse_in ? smc_pkg::PM_ALL_SET
                                               : smc_pkg::PM_ALL_CLR;
  assign p0_low_reset  = tristate_port_fuse_in ? smc_pkg::PM_ALL_CLR
                                               : smc_pkg::PM_ALL_SET;
  assign p0_high_reset = smc_pkg::PM_ALL_SET;

  // flags clear where software writes zero; a new event in the same clock wins
  assign kbf_keep_mask = wr_kbf ? reg_wdata_in : smc_pkg::PM_ALL_SET;
  assign next_kbf      = (keyboard_flag_register & kbf_keep_mask) | keyboard_event_in;

  // port mode bits
  always_ff @(posedge core_clk_in) begin
    if (sys_rst) begin
      for (int p = 0; p < PORTS; p++) begin
        port_low[p]  <= (p == 0) ? p0_low_reset  : low_reset;
        port_high[p] <= (p == 0) ? p0_high_reset : high_reset;
      end
      port_high[PORTS-1] <= smc_pkg::PM_ALL_CLR;
    end else if (clk_en_in) begin
      if (wr_port_low)  port_low[port_index_in]  <= reg_wdata_in;
      if (wr_port_high) port_high[port_index_in] <= reg_wdata_in;
    end
  end

  // clock, auxiliary, timer-output and keyboard registers
  always_ff @(posedge core_clk_in) begin
    if (sys_rst) begin
      clock_reload_divider   <= smc_pkg::CLOCK_RELOAD_DIVIDER_RST;
      clkcfg <= smc_pkg::CLKCFG_RST;
      clkcfg[smc_pkg::TPS_MSB:smc_pkg::TPS_LSB] <=
        reset_fast ? smc_pkg::TPS_RST_FAST : smc_pkg::TPS_RST_COMPAT;
      aux    <= smc_pkg::AUX_RST;
      aux[smc_pkg::AUX_XDATA_BIT] <= xdata_default_fuse_in;
      aux2   <= smc_pkg::AUX2_RST;
      tout   <= smc_pkg::TOUT_RST;
      keyboard_flag_register    <= smc_pkg::KBF_RST;
      dspeed <= reset_fast;
    end else if (clk_en_in) begin
      if (reg_wr_in && reg_sel_in == smc_pkg::SEL_CLK_RELOAD)   clock_reload_divider   <= reg_wdata_in;
      if (reg_wr_in && reg_sel_in == smc_pkg::SEL_CLK_CONFIG)   clkcfg <= reg_wdata_in;
      if (reg_wr_in && reg_sel_in == smc_pkg::SEL_AUX)          aux    <= reg_wdata_in;
      if (reg_wr_in && reg_sel_in == smc_pkg::SEL_AUX2)         aux2   <= reg_wdata_in;
      if (reg_wr_in && reg_sel_in == smc_pkg::SEL_TIMER_OUT)    tout   <= reg_wdata_in;
      if (reg_wr_in && reg_sel_in == smc_pkg::SEL_DOUBLE_SPEED) begin
        dspeed <= reg_wdata_in[smc_pkg::DSPEED_BIT];
      end
      keyboard_flag_register <= next_kbf;
    end
  end

  // flatten port modes for the pad logic
  genvar gp;
  generate
    for (gp = 0; gp < PORTS; gp++) begin : g_port
      assign port_mode_low_bits_out[gp*PINS +: PINS]  = port_low[gp];
      assign port_mode_high_bits_out[gp*PINS +: PINS] = port_high[gp];
    end
  endgenerate

  // register views and field slices, all straight from flops
  assign clock_reload_divider_out              = clock_reload_divider;
  assign clock_config_register_out             = clkcfg;
  assign auxiliary_control_register_out        = aux;
  assign second_auxiliary_control_register_out = aux2;
  assign keyboard_flag_register_out            = keyboard_flag_register;
  assign timer_output_control_register_out     = tout;
  assign double_speed_setting_out              = dspeed;
  assign timer_prescale_select_out  = clkcfg[smc_pkg::TPS_MSB:smc_pkg::TPS_LSB];
  assign latch_strobe_toggle_enable_out = aux[smc_pkg::AUX_LATCH_BIT];
  assign onchip_xdata_enable_out        = aux[smc_pkg::AUX_XDATA_BIT];
  assign xdata_wait_states_out = aux[smc_pkg::AUX_WS_MSB:smc_pkg::AUX_WS_LSB];
  assign extended_stack_select_out      = aux2[smc_pkg::AUX2_STACK_BIT];
  assign flash_api_enable_out           = aux2[smc_pkg::AUX2_API_BIT];

  // ---- system clock divisor: reload factor, then doubled unless double speed
  logic [8:0] reload_factor;
  logic [9:0] next_divisor;

  assign reload_factor = 9'(smc_pkg::DIV_BASE - {1'b0, clock_reload_divider});
  assign next_divisor  = dspeed ? {1'b0, reload_factor} : {reload_factor, 1'b0};

  // the same divisor feeds whichever oscillator is selected
  always_ff @(posedge core_clk_in) begin
    if (sys_rst) begin
      sys_clk_divisor_out <= reset_fast ? 10'h001 : 10'h002;
      osc_b_selected_out  <= 1'b0;
    end else if (clk_en_in) begin
      sys_clk_divisor_out <= next_divisor;
      osc_b_selected_out  <= second_oscillator_source_in;
    end
  end

  // ---- fetch sequencing and instruction length
  smc_pkg::smc_mstate_t mstate;
  smc_pkg::smc_mstate_t next_state;
  logic                 next_fetch;

  // fast mode parks in S1 and fetches every clock
  assign next_state = fast_mode ? smc_pkg::MS_S1 : next_mstate(mstate);
  assign next_fetch = fast_mode || next_state == smc_pkg::MS_S3
                                || next_state == smc_pkg::MS_S6;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst) begin
      mstate           <= smc_pkg::MS_S1;
      fetch_strobe_out <= 1'b0;
      instr_clocks_out <= 5'h00;
    end else if (clk_en_in) begin
      mstate           <= next_state;
      fetch_strobe_out <= next_fetch;
      instr_clocks_out <= instr_clocks(fast_mode, instr_length_in);
    end
  end
  assign machine_state_out = mstate;

  // ---- shared prescaler
  smc_tick_if tick_bus ();

  assign tick_bus.clk_en      = clk_en_in;
  assign tick_bus.sys_rst     = sys_rst;
  assign tick_bus.fast_mode   = fast_mode;
  assign tick_bus.t2_unscaled = timer2_unscaled_mode_in;
  assign tick_bus.timer_prescale_select         = clkcfg[smc_pkg::TPS_MSB:smc_pkg::TPS_LSB];

  smc_prescaler u_prescaler (
    .core_clk_in (core_clk_in),
    .tick_if     (tick_bus)
  );

  assign timer_tick_out  = tick_bus.timer_tick;
  assign timer2_tick_out = tick_bus.t2_tick;
  assign pin_sample_out  = tick_bus.sample_strobe;

  // ---- timer pin toggling and external execution gate
  logic next_ext_allow;

  // nothing below 2000H may run externally; lock mode 4 shuts the rest
  assign next_ext_allow = fetch_external_in && fetch_addr_in >= smc_pkg::EXT_EXEC_FLOOR
                          && !lock_mode4_in;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst) begin
      timer0_pin_out     <= 1'b0;
      timer1_pin_out     <= 1'b0;
      ext_exec_allow_out <= 1'b0;
    end else if (clk_en_in) begin
      timer0_pin_out <= timer0_pin_out
                        ^ (timer0_overflow_in & tout[smc_pkg::TOUT_T0_BIT]);
      timer1_pin_out <= timer1_pin_out
                        ^ (timer1_overflow_in & tout[smc_pkg::TOUT_T1_BIT]);
      ext_exec_allow_out <= next_ext_allow;
    end
  end

endmodule : smc_system_config

// >>> verification/smc_sva.sv
`timescale 1ns/1ps
module smc_sva (
  input logic        core_clk_in,
  input logic        clk_en_in,
  input logic [2:0]  instr_length_in,
  input logic        timer0_overflow_in,
  input logic [15:0] fetch_addr_in,
  input logic        fetch_external_in,
  input logic        lock_mode4_in,
  input logic        fast_mode_out,
  input logic        sys_reset_out,
  input logic [7:0]  clock_config_register_out,
  input logic [7:0]  timer_output_control_register_out,
  input logic [3:0]  timer_prescale_select_out,
  input logic        fetch_strobe_out,
  input logic [4:0]  instr_clocks_out,
  input logic        timer_tick_out,
  input logic        pin_sample_out,
  input logic        timer0_pin_out,
  input logic        ext_exec_allow_out
);
  // frozen cycles carry no timing promise, so they abort any attempt
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (sys_reset_out || !clk_en_in);

  a_tps_field: assert property (timer_prescale_select_out == clock_config_register_out[7:4])
    else $error("prescale field mismatch");
  a_compat_fetch: assert property (!fast_mode_out && fetch_strobe_out |=>
    !fetch_strobe_out ##1 !fetch_strobe_out ##1 fetch_strobe_out) else $error("compat fetch rate");
  a_fast_fetch: assert property (fast_mode_out && !$past(sys_reset_out) && $past(clk_en_in)
    |-> fetch_strobe_out) else $error("fast fetch missing");
  a_instr_clocks: assert property (!sys_reset_out |=> instr_clocks_out == (fast_mode_out ?
    5'($past(instr_length_in)) : 5'h06 * 5'($past(instr_length_in)))) else $error("instr clocks");
  a_ext_exec_gate: assert property (!sys_reset_out |=> ext_exec_allow_out ==
    $past(fetch_external_in && fetch_addr_in >= 16'h2000 && !lock_mode4_in))
    else $error("external fetch gate");
  a_tick_period: assert property (timer_tick_out && timer_prescale_select_out == 4'h5 ##1
    (!timer_tick_out && timer_prescale_select_out == 4'h5)[*5] |=> timer_tick_out)
    else $error("tick period not six");
  a_pin_sample_rate: assert property (!$past(sys_reset_out) && $past(clk_en_in) |->
    pin_sample_out == (fast_mode_out || timer_tick_out)) else $error("pin sample rate");
  a_counter_pin_toggle: assert property (!sys_reset_out |=> timer0_pin_out ==
    ($past(timer0_pin_out) ^ $past(timer0_overflow_in && timer_output_control_register_out[0])))
    else $error("t0 pin");

  cover property (!fast_mode_out && fetch_strobe_out);
  cover property (timer0_overflow_in && timer_output_control_register_out[0]);
  cover property (fetch_external_in && !lock_mode4_in && fetch_addr_in == 16'h2000);
endmodule : smc_sva

bind smc_system_config smc_sva u_sva (.*);

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic core_clk_in, rst_n_in, clk_en_in, compat_mode_fuse_in, tristate_port_fuse_in;
  logic xdata_default_fuse_in, reset_pin_in, reset_polarity_select_in, reg_wr_in;
  logic second_oscillator_source_in, timer2_unscaled_mode_in, timer0_overflow_in;
  logic timer1_overflow_in, fetch_external_in, lock_mode4_in, fast_mode_out, sys_reset_out;
  logic double_speed_setting_out, latch_strobe_toggle_enable_out, onchip_xdata_enable_out;
  logic extended_stack_select_out, flash_api_enable_out, osc_b_selected_out, fetch_strobe_out;
  logic timer_tick_out, timer2_tick_out, pin_sample_out, timer0_pin_out, timer1_pin_out;
  logic ext_exec_allow_out, pin0;
  smc_pkg::smc_reg_sel_t reg_sel_in;
  smc_pkg::smc_mstate_t  machine_state_out;
  logic [2:0]  port_index_in, instr_length_in;
  logic [1:0]  xdata_wait_states_out;
  logic [3:0]  timer_prescale_select_out;
  logic [4:0]  instr_clocks_out;
  logic [9:0]  sys_clk_divisor_out;
  logic [15:0] fetch_addr_in;
  logic [7:0]  reg_wdata_in, keyboard_event_in, clock_reload_divider_out;
  logic [7:0]  clock_config_register_out, auxiliary_control_register_out, keyboard_flag_register_out;
  logic [7:0]  second_auxiliary_control_register_out, timer_output_control_register_out;
  logic [39:0] port_mode_low_bits_out, port_mode_high_bits_out, nt, nf;
  int          num_errors, checks, cycles;

  smc_system_config DUT (.*);

  // free-running system clock
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t %s", $time, what);
    end
  endtask : chk

  // strobe drops one cycle before the next write so it is never reassigned in one step
  task automatic wr(input smc_pkg::smc_reg_sel_t sel, input logic [7:0] d);
    reg_sel_in = sel;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
    @(negedge core_clk_in);
  endtask : wr

  task automatic rst(input logic compat, input logic tri_f);
    compat_mode_fuse_in = compat;
    tristate_port_fuse_in = tri_f;
    rst_n_in = 1'b0;
    repeat (3) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    @(negedge core_clk_in);
  endtask : rst

  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask : wait_n

  task automatic t_compat;
    rst(1'b1, 1'b1);
    chk(clock_config_register_out, 8'h50, "tps compat");
    chk(sys_clk_divisor_out, 10'h002, "div compat");
    chk({fast_mode_out, auxiliary_control_register_out}, 9'h002, "mode aux");
    chk(port_mode_high_bits_out, 40'h00FFFFFFFF, "tri high");
    chk(port_mode_low_bits_out, 40'h0, "tri low");
    {nt, nf} = '0;
    instr_length_in = 3'h4;
    repeat (60) begin
      @(negedge core_clk_in);
      nt = nt + 40'(timer_tick_out);
      nf = nf + 40'(fetch_strobe_out);
    end
    chk(nt, 40'h0A, "tick per six");
    chk(nf, 40'h14, "fetch per three");
    chk(instr_clocks_out, 5'h18, "four cycles");
    chk(machine_state_out, 3'h1, "state after 61 clocks");
    wr(smc_pkg::SEL_AUX, 8'h61);
    chk({latch_strobe_toggle_enable_out, onchip_xdata_enable_out,
         xdata_wait_states_out}, 4'hB, "aux fields");
    wr(smc_pkg::SEL_AUX2, 8'h30);
    chk({extended_stack_select_out, flash_api_enable_out}, 2'h3, "aux2 fields");
    wr(smc_pkg::SEL_CLK_CONFIG, 8'hF0);
    chk(timer_prescale_select_out, 4'hF, "tps write");
    wr(smc_pkg::SEL_DOUBLE_SPEED, 8'h01);
    chk(sys_clk_divisor_out, 10'h001, "halving off");
    port_index_in = 3'h1;
    wr(smc_pkg::SEL_PORT_LOW, 8'hA5);
    port_index_in = 3'h4;
    wr(smc_pkg::SEL_PORT_LOW, 8'hFF);
    chk(port_mode_low_bits_out, 40'h000000A500, "port modes");
    timer2_unscaled_mode_in = 1'b1;
    wait_n(2);
    chk(timer2_tick_out, 1'b1, "t2 unscaled");
    timer2_unscaled_mode_in = 1'b0;
    rst(1'b1, 1'b1);
    chk({auxiliary_control_register_out, second_auxiliary_control_register_out,
         clock_config_register_out, port_mode_low_bits_out}, 64'h0200500000000000, "defaults");
    $display("test compat done");
  endtask : t_compat

  task automatic t_fast;
    rst(1'b0, 1'b0);
    chk({clock_config_register_out, sys_clk_divisor_out, double_speed_setting_out},
        19'h00003, "fast defaults");
    chk({port_mode_low_bits_out, port_mode_high_bits_out}, 80'hFF00000000FF, "ports");
    instr_length_in = 3'h5;
    repeat (3) begin
      @(negedge core_clk_in);
      chk({timer_tick_out, pin_sample_out, fetch_strobe_out}, 3'h7, "full rate");
    end
    chk(instr_clocks_out, 5'h05, "fast instr");
    second_oscillator_source_in = 1'b1;
    wr(smc_pkg::SEL_CLK_RELOAD, 8'hFE);
    wr(smc_pkg::SEL_DOUBLE_SPEED, 8'h00);
    chk({clock_reload_divider_out, osc_b_selected_out, sys_clk_divisor_out}, 19'h7F404, "osc b");
    $display("test fast done");
  endtask : t_fast

  task automatic t_misc;
    keyboard_event_in = 8'h81;
    @(negedge core_clk_in);
    keyboard_event_in = 8'h00;
    wait_n(2);
    chk(keyboard_flag_register_out, 8'h81, "flags stay");
    wr(smc_pkg::SEL_KB_FLAGS, 8'h7F);
    chk(keyboard_flag_register_out, 8'h01, "bit clear");
    wr(smc_pkg::SEL_TIMER_OUT, 8'h01);
    pin0 = timer0_pin_out;
    {timer0_overflow_in, timer1_overflow_in} = 2'h3;
    @(negedge core_clk_in);
    {timer0_overflow_in, timer1_overflow_in} = 2'h0;
    chk({timer0_pin_out, timer1_pin_out}, {~pin0, 1'b0}, "toggle");
    fetch_external_in = 1'b1;
    fetch_addr_in = 16'h1FFF;
    wait_n(2);
    chk(ext_exec_allow_out, 1'b0, "low external");
    fetch_addr_in = 16'h2000;
    wait_n(2);
    chk(ext_exec_allow_out, 1'b1, "high external");
    lock_mode4_in = 1'b1;
    wait_n(2);
    chk(ext_exec_allow_out, 1'b0, "locked");
    $display("test misc done");
  endtask : t_misc

  // polarity alone flips while the pin stays high, so the reset releases without a pin edge
  task automatic t_pin;
    wr(smc_pkg::SEL_AUX, 8'h61);
    reset_pin_in = 1'b1;
    wait_n(12);
    chk(sys_reset_out, 1'b1, "high reset");
    {reset_pin_in, reset_polarity_select_in} = 2'h2;
    wait_n(8);
    chk({sys_reset_out, auxiliary_control_register_out}, 9'h002, "released");
    reset_pin_in = 1'b0;
    wait_n(12);
    chk(sys_reset_out, 1'b1, "low reset");
    $display("test pin done");
  endtask : t_pin

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // hang guard, well above the roughly 140 cycles the tests need
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    {rst_n_in, clk_en_in, reset_polarity_select_in, reg_wr_in, reset_pin_in} = 5'h1C;
    {xdata_default_fuse_in, second_oscillator_source_in, timer2_unscaled_mode_in} = 3'h4;
    {timer0_overflow_in, timer1_overflow_in, fetch_external_in, lock_mode4_in} = 4'h0;
    {compat_mode_fuse_in, tristate_port_fuse_in, port_index_in, instr_length_in} = 8'hC1;
    {reg_wdata_in, keyboard_event_in, fetch_addr_in} = 32'h0;
    reg_sel_in = smc_pkg::SEL_AUX;
    {num_errors, checks, cycles} = '0;
    t_compat();
    t_fast();
    t_misc();
    t_pin();
    report_and_stop();
  end
endmodule : tb_top
